// ### hw/tenbase_t_transceiver_logic.sv
// Digital core of the 10 Mb/s twisted-pair transceiver
`default_nettype none
`include "tenbase_consts.svh"
module tenbase_t_transceiver_logic #(
    parameter int NLP_PERIOD_CYC = `NLP_PERIOD_MS * `NS_PER_MS / `CLK_NS,
    parameter int JABBER_CYC     = `JABBER_MS * `NS_PER_MS / `CLK_NS,
    parameter int UNJAB_CYC      = `UNJAB_MS * `NS_PER_MS / `CLK_NS,
    parameter int LINK_LOSS_CYC  = `LINK_LOSS_MS * `NS_PER_MS / `CLK_NS
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        tx_en,
    input  wire logic        txd,
    output logic             tx_clk,
    output logic             rx_clk,
    output logic             rxd,
    output logic             crs,
    output logic             col,
    output logic             tx_line,
    output logic             tx_line_oe,
    input  wire logic        sq_pos,
    input  wire logic        sq_neg,
    input  wire logic        rx_line,
    output logic             sq_low,
    output logic             link_up
);
    import tenbase_pkg::*;

    localparam logic [4:0] SQ_WIN    = 5'(`SQ_WIN_CYC);
    localparam logic [3:0] BIT_L     = 4'(`BIT_CYC - 1);
    localparam logic [3:0] HALF      = 4'(`HALF_CYC);
    localparam logic [4:0] MID_MIN   = 5'(`MID_MIN_CYC);
    localparam logic [4:0] EOF_GAP   = 5'(`EOF_CYC);
    localparam logic [5:0] HOLD      = 6'(`RXCLK_HOLD_CYC);
    localparam logic [4:0] TAIL_L    = 5'(`TAIL_CYC - 1);
    localparam logic [3:0] NLP_L     = 4'(`NLP_CYC - 1);
    localparam logic [6:0] SQE_DLY_L = 7'(`SQE_DLY_CYC - 1);
    localparam logic [6:0] SQE_LEN_L = 7'(`SQE_LEN_CYC - 1);

    core_state_t q;
    core_state_t d;
    logic        jab_exp;
    logic        unjab_exp;
    logic        nlp_exp;
    logic        loss_exp;
    logic        link_ok;
    logic        tx_act;
    logic        tx_ok;
    logic        pos_e;
    logic        neg_e;
    logic        any_e;
    logic        lp_seen;
    logic        lp_inv;
    logic        pol_set;
    logic        mid;
    logic        bit_end;
    logic        rd_hit;
    logic        wr_hit;
    logic [15:0] rv;

    tenbase_timer #(.LIMIT(JABBER_CYC)) jab_tmr (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .restart (~tx_en),
        .run     (tx_en & ~q.jabber),
        .expired (jab_exp)
    );

    tenbase_timer #(.LIMIT(UNJAB_CYC)) unjab_tmr (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .restart (tx_en | ~q.jabber),
        .run     (1'b1),
        .expired (unjab_exp)
    );

    // Restarted in the cycle a pulse is launched, so pulse starts are
    // exactly one period apart
    tenbase_timer #(.LIMIT(NLP_PERIOD_CYC - 1)) nlp_tmr (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .restart (tx_act | tx_en | (nlp_exp & ~q.nlp_on)),
        .run     (1'b1),
        .expired (nlp_exp)
    );

    tenbase_timer #(.LIMIT(LINK_LOSS_CYC)) loss_tmr (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .restart (lp_seen | (q.sq == SQ_VALID)),
        .run     (1'b1),
        .expired (loss_exp)
    );

    always_comb begin
        d = q;
        lp_seen = 1'b0;
        lp_inv = 1'b0;
        pol_set = 1'b0;
        link_ok = q.force_link | ~loss_exp;
        tx_act = (q.tx != TX_IDLE);
        tx_ok = link_ok & ~q.jabber;
        pos_e = sq_pos & ~q.pos_prev;
        neg_e = sq_neg & ~q.neg_prev;
        any_e = pos_e | neg_e;
        d.pos_prev = sq_pos;
        d.neg_prev = sq_neg;

        // Smart squelch; a lone crossing that fails qualification is a
        // link pulse whose polarity is that of its first crossing
        case (q.sq)
            SQ_IDLE: begin
                d.sq_tmr = '0;
                if (any_e) begin
                    d.sq = SQ_FIRST;
                    d.sq_first_pos = pos_e;
                end
            end
            SQ_FIRST: begin
                d.sq_tmr = q.sq_tmr + 5'h01;
                if (q.sq_first_pos ? neg_e : pos_e) begin
                    d.sq = SQ_SECOND;
                    d.sq_tmr = '0;
                end else if (q.sq_tmr == SQ_WIN) begin
                    d.sq = SQ_IDLE;
                    lp_seen = 1'b1;
                    lp_inv = ~q.sq_first_pos;
                end
            end
            SQ_SECOND: begin
                d.sq_tmr = q.sq_tmr + 5'h01;
                if (q.sq_first_pos ? pos_e : neg_e) begin
                    d.sq = SQ_VALID;
                    d.sq_tmr = '0;
                end else if (q.sq_tmr == SQ_WIN) begin
                    d.sq = SQ_IDLE;
                    lp_seen = 1'b1;
                    lp_inv = ~q.sq_first_pos;
                end
            end
            SQ_VALID: begin
                if (any_e) begin
                    d.sq_tmr = '0;
                end else if (q.sq_tmr == SQ_WIN) begin
                    d.sq = SQ_IDLE;
                end else begin
                    d.sq_tmr = q.sq_tmr + 5'h01;
                end
            end
            default: d.sq = SQ_IDLE;
        endcase
        d.sq_low = (d.sq == SQ_VALID);

        // Manchester decoder: a transition well after the last mid-bit
        // one is the next mid-bit transition; boundary ones are skipped
        d.rx_prev = rx_line;
        if (q.dec_gap != 5'h1f) begin
            d.dec_gap = q.dec_gap + 5'h01;
        end
        if (q.rxclk_ph == BIT_L) begin
            d.rxclk_ph = '0;
        end else begin
            d.rxclk_ph = q.rxclk_ph + 4'h1;
        end
        mid = (q.sq == SQ_VALID) && link_ok && (rx_line != q.rx_prev)
              && (!q.rx_act || q.dec_gap >= MID_MIN);
        if (mid) begin
            d.rxd = rx_line ^ q.pol_inv;
            d.rx_act = 1'b1;
            d.dec_gap = '0;
            d.rxclk_ph = '0;
        end else if (q.rx_act && (q.dec_gap >= EOF_GAP
                     || q.sq != SQ_VALID || !link_ok)) begin
            d.rx_act = 1'b0;
        end

        d.crs = q.rx_act | (~q.full_dup & tx_act);
        if (q.crs && !d.crs) begin
            d.rxclk_hold = HOLD;
        end else if (q.rxclk_hold != 6'h00) begin
            d.rxclk_hold = q.rxclk_hold - 6'h01;
        end
        d.rx_clk = (d.rx_act | d.crs | (d.rxclk_hold != 6'h00))
                   & (d.rxclk_ph < HALF);

        // Heartbeat sequencer
        if (q.sqe_wait) begin
            d.sqe_cnt = q.sqe_cnt + 7'h01;
            if (q.sqe_cnt == SQE_DLY_L) begin
                d.sqe_wait = 1'b0;
                d.sqe_on = 1'b1;
                d.sqe_cnt = '0;
            end
        end else if (q.sqe_on) begin
            d.sqe_cnt = q.sqe_cnt + 7'h01;
            if (q.sqe_cnt == SQE_LEN_L) begin
                d.sqe_on = 1'b0;
            end
        end

        // Encoder; transmit data is taken just before the rising edge
        // of the transmit clock, that is at the last phase of the cell
        if (q.tx_ph == BIT_L) begin
            d.tx_ph = '0;
        end else begin
            d.tx_ph = q.tx_ph + 4'h1;
        end
        d.tx_clk = (d.tx_ph < HALF);
        bit_end = (q.tx_ph == BIT_L);
        case (q.tx)
            TX_IDLE: begin
                if (bit_end && tx_en && tx_ok) begin
                    d.tx = TX_DATA;
                    d.tx_bit = txd;
                end
            end
            TX_DATA: begin
                if (bit_end) begin
                    if (tx_en && tx_ok) begin
                        d.tx_bit = txd;
                    end else begin
                        d.tx = TX_TAIL;
                        d.tail_cnt = '0;
                    end
                end
            end
            TX_TAIL: begin
                d.tail_cnt = q.tail_cnt + 5'h01;
                if (q.tail_cnt == TAIL_L) begin
                    d.tx = TX_IDLE;
                    d.sqe_wait = 1'b1;
                    d.sqe_on = 1'b0;
                    d.sqe_cnt = '0;
                end
            end
            default: d.tx = TX_IDLE;
        endcase
        if (q.full_dup || q.hbd) begin
            d.sqe_wait = 1'b0;
            d.sqe_on = 1'b0;
        end

        // Link pulses only while nothing is being sent
        if (nlp_exp && !q.nlp_on && !tx_act && !tx_en) begin
            d.nlp_on = 1'b1;
            d.nlp_cnt = '0;
        end else if (q.nlp_on) begin
            d.nlp_cnt = q.nlp_cnt + 4'h1;
            if (q.nlp_cnt == NLP_L) begin
                d.nlp_on = 1'b0;
            end
        end

        if (d.tx == TX_DATA) begin
            d.tx_line = (d.tx_ph < HALF) ? ~d.tx_bit : d.tx_bit;
            d.tx_oe = 1'b1;
        end else if (d.tx == TX_TAIL) begin
            d.tx_line = 1'b1;
            d.tx_oe = 1'b1;
        end else begin
            d.tx_line = d.nlp_on;
            d.tx_oe = d.nlp_on;
        end

        d.jabber = q.jabber ? ~unjab_exp : jab_exp;
        d.col = q.jabber | q.sqe_on
                | (~q.full_dup & link_ok & tx_act & q.rx_act);

        // Polarity: three pulses in a row against the current sense flip it
        if (lp_seen) begin
            if (lp_inv != q.pol_inv) begin
                if (q.inv_cnt == 2'h2) begin
                    d.pol_inv = ~q.pol_inv;
                    d.inv_cnt = '0;
                    pol_set = ~q.pol_inv;
                end else begin
                    d.inv_cnt = q.inv_cnt + 2'h1;
                end
            end else begin
                d.inv_cnt = '0;
            end
        end

        rd_hit = reg_rd && (reg_addr == `REG_TBSC);
        wr_hit = reg_wr && (reg_addr == `REG_TBSC);
        rv = '0;
        rv[`TBSC_JABBER] = q.jabber;
        rv[`TBSC_LINK] = link_ok;
        rv[`TBSC_POL_BAD] = q.pol_bad;
        rv[`TBSC_POL_INV] = q.pol_inv;
        rv[`TBSC_HBD] = q.hbd;
        rv[`TBSC_FORCE] = q.force_link;
        rv[`TBSC_FDX] = q.full_dup;
        d.rdata = rd_hit ? rv : 16'h0000;
        d.pol_bad = (q.pol_bad & ~rd_hit) | pol_set;
        if (wr_hit) begin
            d.hbd = reg_wdata[`TBSC_HBD];
            d.force_link = reg_wdata[`TBSC_FORCE];
            d.full_dup = reg_wdata[`TBSC_FDX];
        end
        d.link = link_ok;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            q <= '0;
            q.hbd <= `TBSC_HBD_RST;
            q.force_link <= `TBSC_FORCE_RST;
            q.full_dup <= `TBSC_FDX_RST;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign tx_clk = q.tx_clk;
    assign rx_clk = q.rx_clk;
    assign rxd = q.rxd;
    assign crs = q.crs;
    assign col = q.col;
    assign tx_line = q.tx_line;
    assign tx_line_oe = q.tx_oe;
    assign sq_low = q.sq_low;
    assign link_up = q.link;

    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    fdx_no_col_a: assert property (
        $past(q.full_dup) && !$past(q.jabber) |-> !col)
        else $error("collision raised in full duplex");
    sq_win_a: assert property (
        q.sq == SQ_FIRST && q.sq_tmr == SQ_WIN
        && !(q.sq_first_pos ? neg_e : pos_e) |=> q.sq == SQ_IDLE)
        else $error("squelch window not enforced");
    rx_qual_a: assert property (
        $rose(q.rx_act) |-> $past(q.sq) == SQ_VALID)
        else $error("receive started before qualification");
    sq_eop_a: assert property (
        q.sq == SQ_VALID && !any_e && q.sq_tmr == SQ_WIN
        |=> q.sq == SQ_IDLE)
        else $error("end of packet not detected");
    sq_lower_a: assert property (
        q.sq == SQ_SECOND ##1 q.sq == SQ_VALID |-> sq_low)
        else $error("thresholds not lowered");
    half_col_a: assert property (
        !q.full_dup && link_ok && tx_act && q.rx_act |=> col)
        else $error("half duplex collision missed");
    jab_col_a: assert property (
        q.jabber |=> col)
        else $error("jabber not reported as collision");
    sqe_delay_a: assert property (
        $rose(q.sqe_on) |-> $past(q.sqe_cnt) == SQE_DLY_L)
        else $error("heartbeat delay wrong");
    hb_off_a: assert property (
        $past(q.full_dup | q.hbd) |-> !q.sqe_on && !q.sqe_wait)
        else $error("heartbeat not suppressed");
    crs_tx_a: assert property (
        !q.full_dup && tx_act |=> crs)
        else $error("carrier missing during transmit");
    fdx_crs_a: assert property (
        q.full_dup && !q.rx_act |=> !crs)
        else $error("carrier from own transmit in full duplex");
    eof_a: assert property (
        q.rx_act && q.dec_gap >= EOF_GAP && !mid |=> !q.rx_act)
        else $error("end of frame not detected");
    rxclk_hold_a: assert property (
        $fell(crs) |-> q.rxclk_hold == HOLD)
        else $error("receive clock hold not started");
    nlp_width_a: assert property (
        $rose(q.nlp_on) |-> tx_line_oe [*8])
        else $error("link pulse too short");
    link_rx_a: assert property (
        !link_ok |=> !q.rx_act)
        else $error("receiver active without link");
    force_a: assert property (
        q.force_link && $past(q.force_link) |-> link_up)
        else $error("forced link not good");
    jab_cut_a: assert property (
        $rose(q.jabber) |-> ##[1:30] q.tx == TX_IDLE)
        else $error("jabber did not cut transmit");
    jab_hold_a: assert property (
        $past(q.jabber) && q.jabber && $past(q.tx) == TX_IDLE
        |-> q.tx == TX_IDLE)
        else $error("transmit restarted while jabbered");
    pol_a: assert property (
        lp_seen && lp_inv != q.pol_inv && q.inv_cnt == 2'h2
        |=> q.pol_inv != $past(q.pol_inv))
        else $error("polarity not corrected");
    tx_start_a: assert property (
        q.tx == TX_IDLE && bit_end && tx_en && tx_ok
        |=> q.tx == TX_DATA && q.tx_bit == $past(txd))
        else $error("transmit start missed");
    tail_a: assert property (
        $past(q.tx) == TX_TAIL && q.tx == TX_IDLE |-> $past(tx_line))
        else $error("frame did not end high");
    unjab_a: assert property (
        q.jabber && !unjab_exp |=> q.jabber)
        else $error("jabber cleared early");

    qual_c: cover property (q.sq == SQ_SECOND ##1 q.sq == SQ_VALID);
    jab_c: cover property ($rose(q.jabber));
    sqe_c: cover property ($fell(q.sqe_on));
    pol_c: cover property ($rose(q.pol_bad));
endmodule
`default_nettype wire

// ### hw/tenbase_consts.svh
// Timing, register and field constants for the 10 Mb/s transceiver logic
// Behaviour
// - Full duplex sends and receives together, raising collision only on jabber.
// - Squelch needs first level, opposite within 150 ns, original within 150 ns.
// - Qualification is duplex independent; about two preamble bits are lost.
// - Data stays valid until no level crossing for over 150 ns.
// - Once data is good, squelch thresholds are lowered.
// - Half duplex: collision while transmit and receive overlap, reported at once.
// - Collision is also raised during a jabber condition.
// - Heartbeat: about 1 us after each frame, collision pulses ten bit times.
// - Heartbeat is suppressed in full duplex or by the suppress bit.
// - Half duplex carrier sense follows transmit or qualified receive.
// - Full duplex carrier sense follows receive only.
// - End of frame when mid-bit transitions stop; carrier drops within 1.5 bits.
// - Receive clock runs five more bit times after carrier sense falls.
// - When idle, a 100 ns link pulse goes out every 16 ms.
// - Without valid link pulses, transmitter and receiver are disabled, and collision except on jabber; the heartbeat collision is not gated by link.
// - The force-link bit makes the link good regardless of pulses.
// - Jabber cuts transmission after about 85 ms of continuous transmit.
// - After jabber, transmit stays off until enable is low about 500 ms.
// - Three inverted link pulses latch bad polarity and invert decoding.
// - Serial transmit data is sampled each bit and encoded while enable is high.
// - Each frame ends with a positive transition: mid-cell for one, boundary for zero.
`ifndef TENBASE_CONSTS_SVH
`define TENBASE_CONSTS_SVH

`define CLK_NS          10
`define NS_PER_MS       1000000
`define BIT_NS          100
`define BIT_CYC         (`BIT_NS / `CLK_NS)
`define HALF_CYC        (`BIT_CYC / 2)
`define SQ_WIN_NS       150
`define SQ_WIN_CYC      (`SQ_WIN_NS / `CLK_NS)
`define MID_MIN_NS      70
`define MID_MIN_CYC     ((`MID_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define EOF_NS          130
`define EOF_CYC         (`EOF_NS / `CLK_NS)
`define RXCLK_HOLD_BITS 5
`define RXCLK_HOLD_CYC  (`RXCLK_HOLD_BITS * `BIT_CYC)
`define TAIL_BITS       2
`define TAIL_CYC        (`TAIL_BITS * `BIT_CYC)
`define NLP_NS          100
`define NLP_CYC         (`NLP_NS / `CLK_NS)
`define SQE_DLY_NS      1000
`define SQE_DLY_CYC     (`SQE_DLY_NS / `CLK_NS)
`define SQE_LEN_BITS    10
`define SQE_LEN_CYC     (`SQE_LEN_BITS * `BIT_CYC)
`define NLP_PERIOD_MS   16
`define JABBER_MS       85
`define UNJAB_MS        500
`define LINK_LOSS_MS    50

`define REG_TBSC        5'h1a
`define TBSC_JABBER     0
`define TBSC_LINK       1
`define TBSC_POL_BAD    4
`define TBSC_POL_INV    5
`define TBSC_HBD        7
`define TBSC_FORCE      8
`define TBSC_FDX        9
`define TBSC_HBD_RST    1'b0
`define TBSC_FORCE_RST  1'b0
`define TBSC_FDX_RST    1'b0

`endif

// ### hw/tenbase_pkg.sv
// Types for the 10 Mb/s transceiver logic
`default_nettype none
package tenbase_pkg;

    typedef enum logic [1:0] {SQ_IDLE, SQ_FIRST, SQ_SECOND, SQ_VALID}
        sq_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_TAIL} tx_state_t;

    typedef struct packed {
        sq_state_t   sq;
        logic        sq_first_pos;
        logic [4:0]  sq_tmr;
        logic        pos_prev;
        logic        neg_prev;
        logic        sq_low;
        logic        rx_prev;
        logic [4:0]  dec_gap;
        logic        rx_act;
        logic        rxd;
        logic [3:0]  rxclk_ph;
        logic [5:0]  rxclk_hold;
        logic        rx_clk;
        logic        crs;
        logic        col;
        logic [1:0]  inv_cnt;
        logic        pol_inv;
        logic        pol_bad;
        tx_state_t   tx;
        logic [3:0]  tx_ph;
        logic        tx_clk;
        logic        tx_bit;
        logic [4:0]  tail_cnt;
        logic        tx_line;
        logic        tx_oe;
        logic        nlp_on;
        logic [3:0]  nlp_cnt;
        logic        jabber;
        logic        sqe_wait;
        logic        sqe_on;
        logic [6:0]  sqe_cnt;
        logic        hbd;
        logic        force_link;
        logic        full_dup;
        logic        link;
        logic [15:0] rdata;
    } core_state_t;

endpackage
`default_nettype wire

// ### hw/tenbase_timer.sv
// Saturating interval timer with restart and a registered expiry level
`default_nettype none
module tenbase_timer #(
    parameter int LIMIT = 16
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic restart,
    input  wire logic run,
    output logic      expired
);
    localparam int W = $clog2(LIMIT + 1);
    localparam logic [W-1:0] LIM = W'(LIMIT);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         done;
    } tmr_state_t;

    tmr_state_t q;
    tmr_state_t d;

    always_comb begin
        d = q;
        if (restart) begin
            d.cnt = '0;
        end else if (run && q.cnt != LIM) begin
            d.cnt = q.cnt + 1'b1;
        end
        d.done = (d.cnt == LIM);
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign expired = q.done;
endmodule
`default_nettype wire

// ### verification/remote_station.sv
// Remote station model: squelch comparators and line sense
`default_nettype none
module remote_station (
    input  wire logic clk_sys,
    output logic      sq_pos,
    output logic      sq_neg,
    output logic      rx_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic   busy = 1'b0;
    logic   on   = 1'b1;
    logic   inv  = 1'b0;
    integer seed = 58;
    initial {sq_pos, sq_neg, rx_line} = 3'h0;
    task automatic half(input logic v);
        sq_pos <= v;
        sq_neg <= ~v;
        rx_line <= v;
        repeat (5) @(posedge clk_sys);
    endtask
    // Preamble first, so the squelch sees crossings 5 and 10 cycles apart
    task automatic frame(input int n);
        logic b;
        while (busy) @(posedge clk_sys);
        busy = 1'b1;
        for (int i = 0; i < n; i++) begin
            b = (i < 16) ? ~i[0] : 1'($random(seed));
            half(~b);
            half(b);
        end
        {sq_pos, sq_neg} <= 2'h0;
        busy = 1'b0;
        fork
            begin
                repeat (20) @(posedge clk_sys);
                rx_line <= ~rx_line;
            end
        join_none
    endtask
    task automatic pulse();
        busy = 1'b1;
        sq_pos <= ~inv;
        sq_neg <= inv;
        rx_line <= ~inv;
        repeat (10) @(posedge clk_sys);
        {sq_pos, sq_neg} <= 2'h0;
        rx_line <= inv;
        busy = 1'b0;
    endtask
    always begin
        repeat (1000) @(posedge clk_sys);
        if (on && !busy) pulse();
    end
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the 10 Mb/s transceiver core
`default_nettype none
`include "tenbase_consts.svh"
`define CHK(n, e, a) \
    begin if ((a) !== (e)) begin \
        $display("ERROR %s expected %h seen %h", n, e, a); \
        failures++; end comparisons++; end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, resetn, reg_wr, reg_rd, tx_en, txd;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic        tx_clk, rx_clk, rxd, crs, col, tx_line, tx_line_oe;
    logic        sq_pos, sq_neg, rx_line, sq_low, link_up;
    integer      seed = 58, failures = 0, comparisons = 0;
    int          cyc = 0, ncol = 0, ncrs = 0, noe = 0, k, ntx;
    tenbase_t_transceiver_logic #(.NLP_PERIOD_CYC(200), .JABBER_CYC(500),
        .UNJAB_CYC(800), .LINK_LOSS_CYC(3000))
        tenbase_t_transceiver_logic_inst (.clk_sys, .resetn, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_en, .txd, .tx_clk,
        .rx_clk, .rxd, .crs, .col, .tx_line, .tx_line_oe, .sq_pos,
        .sq_neg, .rx_line, .sq_low, .link_up);
    remote_station remote_station_inst (.clk_sys, .sq_pos, .sq_neg,
        .rx_line);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        ncol += (col === 1'b1);
        ncrs += (crs === 1'b1);
        noe += (tx_line_oe === 1'b1);
        if (cyc == 20000) begin
            failures++;
            summarize();
        end
    end
    task automatic summarize();
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys) reg_rd <= 1'b0;
        #1 `CHK("reg_rdata", e, reg_rdata)
        @(posedge clk_sys);
    endtask
    // Bits change one clock after each rising edge of tx_clk
    task automatic txf(input int n);
        @(negedge tx_clk);
        for (int i = 0; i <= n; i++) begin
            @(posedge clk_sys);
            tx_en <= (i < n);
            txd <= 1'($random(seed));
            @(posedge tx_clk);
        end
    endtask
    initial begin
        {resetn, reg_wr, reg_rd, tx_en, txd} <= 5'h00;
        reg_addr <= 5'h00;
        reg_wdata <= 16'h0000;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        rd(5'h1a, 16'h0002);
        rd(5'h05, 16'h0000);
        wr(5'h1a, 16'hffff);
        rd(5'h1a, 16'h0382);
        wr(5'h1a, 16'h0000);
        @(posedge tx_line_oe) k = cyc;
        @(negedge tx_line_oe) `CHK("nlp_len", `NLP_CYC, cyc - k)
        @(posedge tx_line_oe) `CHK("nlp_gap", 200, cyc - k)
        {ncol, ncrs} = 0;
        txf(30);
        `CHK("crs_tx", 1'b1, ncrs > 250)
        `CHK("col_tx", 0, ncol)
        repeat (5) @(posedge clk_sys);
        `CHK("tail", 1'b1, tx_line)
        repeat (300) @(posedge clk_sys);
        `CHK("sqe_len", `SQE_LEN_CYC, ncol)
        wr(5'h1a, 16'h0080);
        ncol = 0;
        txf(10);
        repeat (300) @(posedge clk_sys);
        `CHK("sqe_off", 0, ncol)
        wr(5'h1a, 16'h0000);
        fork
            txf(40);
            remote_station_inst.frame(30);
        join
        `CHK("col_half", 1'b1, ncol > 100)
        repeat (400) @(posedge clk_sys);
        ncrs = 0;
        remote_station_inst.frame(40);
        `CHK("sq_low", 1'b1, sq_low)
        `CHK("rxd", rx_line, rxd)
        `CHK("crs_rx", 1'b1, ncrs > 300)
        for (k = 0; crs === 1'b1 && k < 40; k++) @(posedge clk_sys);
        `CHK("crs_drop", 1'b1, k <= 15)
        k = 0;
        ntx = 0;
        repeat (50) begin
            @(posedge clk_sys);
            k += (rx_clk === 1'b1);
            ntx += (tx_clk === 1'b1);
        end
        `CHK("rx_clk_hold", 1'b1, k >= 20)
        `CHK("tx_clk_high", 5 * `HALF_CYC, ntx)
        wr(5'h1a, 16'h0200);
        {ncol, ncrs} = 0;
        txf(20);
        `CHK("crs_fdx", 0, ncrs)
        fork
            txf(40);
            remote_station_inst.frame(30);
        join
        repeat (300) @(posedge clk_sys);
        `CHK("col_fdx", 0, ncol)
        wr(5'h1a, 16'h0000);
        noe = 0;
        txf(60);
        `CHK("oe_jab", 1'b1, noe < 560)
        `CHK("col_jab", 1'b1, col)
        repeat (700) @(posedge clk_sys);
        rd(5'h1a, 16'h0003);
        repeat (150) @(posedge clk_sys);
        rd(5'h1a, 16'h0002);
        remote_station_inst.on = 1'b0;
        wait (!remote_station_inst.busy);
        remote_station_inst.inv = 1'b1;
        repeat (3) begin
            remote_station_inst.pulse();
            repeat (100) @(posedge clk_sys);
        end
        rd(5'h1a, 16'h0032);
        rd(5'h1a, 16'h0022);
        repeat (3100) @(posedge clk_sys);
        `CHK("link_up", 1'b0, link_up)
        ncrs = 0;
        txf(10);
        `CHK("tx_refused", 0, ncrs)
        wr(5'h1a, 16'h0100);
        repeat (2) @(posedge clk_sys);
        `CHK("link_forced", 1'b1, link_up)
        summarize();
    end
endmodule
`default_nettype wire
